/* rtl/dbt_defs.svh */
// timing counts and field constants for one bus channel's bit timing block
// assumes a 125 MHz core clock; every count below except the spreading step is derived from that rate
`ifndef DBT_DEFS_SVH
`define DBT_DEFS_SVH

`define DBT_CLK_MHZ        125
// nominal bit period, centre of the spreading band
`define DBT_BIT_NS         7220
`define DBT_BIT_CYC        ((`DBT_BIT_NS * `DBT_CLK_MHZ) / 1000)
// shortest legal bit period, rounded up
`define DBT_BIT_PERIOD_MIN_NS    6670
`define DBT_BIT_PERIOD_MIN_CYC   ((`DBT_BIT_PERIOD_MIN_NS * `DBT_CLK_MHZ + 999) / 1000)
`define DBT_LO_TRIM_NS     600
`define DBT_LO_TRIM_CYC    ((`DBT_LO_TRIM_NS * `DBT_CLK_MHZ) / 1000)
`define DBT_LO1_CYC        (`DBT_BIT_CYC / 3 - `DBT_LO_TRIM_CYC)
`define DBT_LO0_CYC        ((2 * `DBT_BIT_CYC) / 3 - `DBT_LO_TRIM_CYC)
`define DBT_START_CYC      (`DBT_BIT_CYC / 2)
`define DBT_OC_NS          5000
`define DBT_OC_CYC         ((`DBT_OC_NS * `DBT_CLK_MHZ) / 1000)
`define DBT_OC_MIN_NS      2000
`define DBT_OC_MIN_CYC     ((`DBT_OC_MIN_NS * `DBT_CLK_MHZ + 999) / 1000)
`define DBT_OC_MAX_NS      20000
`define DBT_OC_MAX_CYC     ((`DBT_OC_MAX_NS * `DBT_CLK_MHZ) / 1000)
`define DBT_DEV10_NS       500
`define DBT_DEV10_CYC      ((`DBT_DEV10_NS * `DBT_CLK_MHZ) / 1000)
`define DBT_DEV01_NS       950
`define DBT_DEV01_CYC      ((`DBT_DEV01_NS * `DBT_CLK_MHZ) / 1000)
`define DBT_SPREAD_STEP    8
`define DBT_DEV_SEL_NARROW 2'b10
`define DBT_DEV_SEL_WIDE   2'b01
`define DBT_CRC_POLY       8'h07
`define DBT_CRC_INIT       8'hff
`define DBT_PIN_CS         0
`define DBT_PIN_SCLK       1
`define DBT_PIN_OC         2

`endif

/* rtl/dbt_pkg.sv */
// types shared by the bit timing block and its spreading generator
// assumes nothing beyond the compiler
`default_nettype none

package dbt_pkg;

   typedef enum logic [2:0] {
      DBT_ST_IDLE  = 3'b000,
      DBT_ST_ARM   = 3'b001,
      DBT_ST_DELAY = 3'b010,
      DBT_ST_LOW   = 3'b011,
      DBT_ST_HIGH  = 3'b100
   } dbt_state_t;

   typedef struct packed {
      logic [15:0] data;
      logic [4:0]  nbits;
      logic [3:0]  crc_len;
   } dbt_msg_t;

   typedef struct packed {
      logic       en;
      logic [1:0] spread_deviation_sel;
   } dbt_spread_cfg_t;

endpackage

`default_nettype wire

/* rtl/dbt_spread.sv */
// triangle sweep of the bit period offset used for frequency spreading
// assumes step_i pulses once per transmitted bit from the same clock
`default_nettype none
`include "dbt_defs.svh"

module dbt_spread (
   input  wire logic                   clk_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   step_i,
   input  wire dbt_pkg::dbt_spread_cfg_t cfg_i,
   output logic signed [7:0]           offset_o
);
   logic signed [7:0] acc_reg;
   logic signed [7:0] acc_next;
   logic signed [7:0] lim_reg;
   logic signed [7:0] lim_next;
   logic              up_reg;
   logic              up_next;

   always_comb begin
      lim_next = 8'sh00;
      if (cfg_i.en && cfg_i.spread_deviation_sel == `DBT_DEV_SEL_NARROW) begin
         lim_next = 8'(`DBT_DEV10_CYC); // R09
      end else if (cfg_i.en && cfg_i.spread_deviation_sel == `DBT_DEV_SEL_WIDE) begin
         lim_next = 8'(`DBT_DEV01_CYC); // R09
      end
   end

   always_comb begin
      acc_next = acc_reg;
      up_next  = up_reg;
      if (acc_reg > lim_next || acc_reg < -lim_next) begin
         // a narrower setting pulls back to the centre at once
         acc_next = 8'sh00; // R13
      end else if (step_i) begin
         if (up_reg) begin
            if (acc_reg + 8'(`DBT_SPREAD_STEP) >= lim_next) begin
               acc_next = lim_next;
               up_next  = 1'b0;
            end else begin
               acc_next = acc_reg + 8'(`DBT_SPREAD_STEP);
            end
         end else begin
            if (acc_reg - 8'(`DBT_SPREAD_STEP) <= -lim_next) begin
               acc_next = -lim_next;
               up_next  = 1'b1;
            end else begin
               acc_next = acc_reg - 8'(`DBT_SPREAD_STEP);
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         acc_reg <= 8'sh00;
         lim_reg <= 8'sh00;
         up_reg  <= 1'b1;
      end else begin
         acc_reg <= acc_next;
         lim_reg <= lim_next;
         up_reg  <= up_next;
      end
   end

   assign offset_o = acc_reg;

   a_dev_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R09
      (acc_reg <= lim_reg) && (acc_reg >= -lim_reg))
      else $error("spread offset outside selected deviation");

endmodule // dbt_spread

`default_nettype wire

/* rtl/dbt_bit_timing.sv */
// bit timing, start latency, interrupt pin and overcurrent cut-off of one bus channel
// assumes spi pins arrive asynchronously and queue status comes from logic on clk_i
// Summary of operation
// [R01] bit period never below 6.67 us
// [R02] zero bit low two thirds period minus 0.6us
// [R03] one bit low one third period minus 0.6us
// [R04] first bus edge one to two thirds period later
// [R05] latency measured from word end edge
// [R06] interrupt asserted soon after receive data arrives
// [R07] interrupt released within 0.2 us of word end
// [R08] overcurrent cuts driver after 2 to 20 us
// [R09] two-bit setting picks spreading deviation
// [R10] system supplies the logic clock
// [R11] duty coded return-to-one bits with appended crc
// [R12] clear conditions checked at each spi word end
// [R13] period fixed without spreading, swept with it
`default_nettype none
`include "dbt_defs.svh"

module dbt_bit_timing (
   input  wire logic                     clk_i,
   input  wire logic                     sys_rst_i,
   input  wire logic                     spi_cs_n_i,
   input  wire logic                     spi_sclk_i,
   input  wire logic                     tx_start_i,
   input  wire dbt_pkg::dbt_msg_t        tx_msg_i,
   input  wire dbt_pkg::dbt_spread_cfg_t spread_cfg_i,
   input  wire logic                     int_en_i,
   input  wire logic                     rx_ready_i,
   input  wire logic                     tx_empty_i,
   input  wire logic                     tx_not_empty_i,
   input  wire logic                     rx_empty_i,
   input  wire logic                     oc_detect_i,
   input  wire logic                     oc_clear_i,
   output logic                          channel_low_side_line_o,
   output logic                          driver_en_o,
   output logic                          oc_shutdown_o,
   output logic                          busy_o,
   output logic                          frame_done_o,
   output logic                          int_o,
   output logic                          int_oe_o
);
   localparam int ST_MIN = `DBT_BIT_CYC / 3;
   localparam int ST_MAX = (2 * `DBT_BIT_CYC) / 3;

   // pin synchronisers: a change counts once stages two and three agree
   logic [2:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_d_reg;
   logic [2:0] pin_w, filt_next;
   assign pin_w = {oc_detect_i, spi_sclk_i, spi_cs_n_i};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_pin
         assign filt_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : filt_reg[g];
      end
   endgenerate

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_reg     <= 3'h3;
         s2_reg     <= 3'h3;
         s3_reg     <= 3'h3;
         filt_reg   <= 3'h3;
         filt_d_reg <= 3'h3;
      end else begin
         s1_reg     <= pin_w;
         s2_reg     <= s1_reg;
         s3_reg     <= s2_reg;
         filt_reg   <= filt_next;
         filt_d_reg <= filt_reg;
      end
   end

   // spi word boundaries
   logic       cs_rise, sclk_rise, word_end, cs_high;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic       byte_seen_reg, byte_seen_next;
   assign cs_high   = filt_reg[`DBT_PIN_CS];
   assign cs_rise   = cs_high & ~filt_d_reg[`DBT_PIN_CS];
   assign sclk_rise = filt_reg[`DBT_PIN_SCLK] & ~filt_d_reg[`DBT_PIN_SCLK] & ~cs_high;
   // the triggering byte ends either at cs rising or at the next byte's first clock
   assign word_end  = cs_rise | (sclk_rise & (bit_cnt_reg == 3'h0) & byte_seen_reg); // R05

   always_comb begin
      bit_cnt_next   = bit_cnt_reg;
      byte_seen_next = byte_seen_reg;
      if (cs_high) begin
         bit_cnt_next   = 3'h0;
         byte_seen_next = 1'b0;
      end else if (sclk_rise) begin
         bit_cnt_next = bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == 3'h7) begin
            byte_seen_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bit_cnt_reg   <= 3'h0;
         byte_seen_reg <= 1'b0;
      end else begin
         bit_cnt_reg   <= bit_cnt_next;
         byte_seen_reg <= byte_seen_next;
      end
   end

   // overcurrent: only a sustained flag counts, a glitch restarts the count
   logic [11:0] oc_cnt_reg, oc_cnt_next;
   logic        shut_reg, shut_next;
   // own flop so the driver enable pin comes straight off a register
   logic        drv_en_reg;

   always_comb begin
      oc_cnt_next = 12'h000;
      shut_next   = shut_reg;
      if (oc_clear_i) begin
         shut_next = 1'b0;
      end
      if (filt_reg[`DBT_PIN_OC] && !shut_reg) begin
         oc_cnt_next = oc_cnt_reg + 12'h001;
         if (oc_cnt_reg == 12'(`DBT_OC_CYC - 1)) begin
            shut_next   = 1'b1; // R08
            oc_cnt_next = 12'h000;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         oc_cnt_reg <= 12'h000;
         shut_reg   <= 1'b0;
         drv_en_reg <= 1'b1;
      end else begin
         oc_cnt_reg <= oc_cnt_next;
         shut_reg   <= shut_next;
         drv_en_reg <= ~shut_next; // R08
      end
   end

   // transmit state machine
   dbt_pkg::dbt_state_t state_reg, state_next;
   dbt_pkg::dbt_msg_t   msg_reg, msg_next;
   logic [15:0] sh_reg, sh_next;
   logic [7:0]  crc_reg, crc_next;
   logic [10:0] cnt_reg, cnt_next, per_reg, per_next, lo_reg, lo_next, per_raw;
   logic [4:0]  idx_reg, idx_next;
   logic        line_reg, line_next, bit_reg, bit_next, done_reg, done_next, load;
   logic        b;
   logic signed [7:0] offset_w;

   dbt_spread u_spread (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .step_i    (load),
      .cfg_i     (spread_cfg_i),
      .offset_o  (offset_w)
   );

   assign per_raw = 11'(`DBT_BIT_CYC) + {{3{offset_w[7]}}, offset_w}; // R13

   always_comb begin
      state_next = state_reg;
      msg_next   = msg_reg;
      sh_next    = sh_reg;
      crc_next   = crc_reg;
      cnt_next   = cnt_reg + 11'h001;
      per_next   = per_reg;
      lo_next    = lo_reg;
      idx_next   = idx_reg;
      line_next  = line_reg;
      bit_next   = bit_reg;
      done_next  = 1'b0;
      load       = 1'b0;
      b          = 1'b0;
      case (state_reg)
         dbt_pkg::DBT_ST_IDLE: begin
            cnt_next = 11'h000;
            if (tx_start_i) begin
               msg_next   = tx_msg_i;
               state_next = dbt_pkg::DBT_ST_ARM;
            end
         end
         dbt_pkg::DBT_ST_ARM: begin
            cnt_next = 11'h000;
            if (word_end) begin
               state_next = dbt_pkg::DBT_ST_DELAY; // R05
            end
         end
         dbt_pkg::DBT_ST_DELAY: begin
            if (cnt_reg == 11'(`DBT_START_CYC - 1)) begin
               sh_next  = msg_reg.data << (5'd16 - msg_reg.nbits);
               crc_next = `DBT_CRC_INIT;
               idx_next = 5'h00;
               load     = 1'b1; // R04
            end
         end
         dbt_pkg::DBT_ST_LOW: begin
            if (cnt_reg == lo_reg - 11'h001) begin
               line_next  = 1'b1; // R11
               state_next = dbt_pkg::DBT_ST_HIGH;
            end
         end
         dbt_pkg::DBT_ST_HIGH: begin
            if (cnt_reg == per_reg - 11'h001) begin
               if (idx_reg == msg_reg.nbits + {1'b0, msg_reg.crc_len}) begin
                  state_next = dbt_pkg::DBT_ST_IDLE;
                  done_next  = 1'b1;
               end else begin
                  load = 1'b1;
               end
            end
         end
         default: begin
            state_next = dbt_pkg::DBT_ST_IDLE;
         end
      endcase
      if (load) begin
         // data bits first, then the top crc_len bits of the running crc
         if (idx_next < msg_reg.nbits) begin
            b        = sh_next[15];
            sh_next  = {sh_next[14:0], 1'b0};
            crc_next = {crc_next[6:0], 1'b0} ^ ((b ^ crc_next[7]) ? `DBT_CRC_POLY : 8'h00); // R11
         end else begin
            b        = crc_next[7];
            crc_next = {crc_next[6:0], 1'b0};
         end
         bit_next   = b;
         lo_next    = b ? 11'(`DBT_LO1_CYC) : 11'(`DBT_LO0_CYC); // R02 R03
         // the clamp makes the wide sweep lopsided: up to 118 cycles long but only 68 short
         per_next   = (per_raw < 11'(`DBT_BIT_PERIOD_MIN_CYC)) ? 11'(`DBT_BIT_PERIOD_MIN_CYC) : per_raw; // R01
         idx_next   = idx_next + 5'h01;
         cnt_next   = 11'h000;
         line_next  = 1'b0;
         state_next = dbt_pkg::DBT_ST_LOW;
      end
      if (shut_reg) begin
         // cut-off abandons the frame and leaves the line at idle
         state_next = dbt_pkg::DBT_ST_IDLE; // R08
         line_next  = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= dbt_pkg::DBT_ST_IDLE;
         msg_reg   <= '0;
         sh_reg    <= 16'h0000;
         crc_reg   <= 8'h00;
         cnt_reg   <= 11'h000;
         per_reg   <= 11'(`DBT_BIT_CYC);
         lo_reg    <= 11'(`DBT_LO1_CYC);
         idx_reg   <= 5'h00;
         line_reg  <= 1'b1;
         bit_reg   <= 1'b0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         msg_reg   <= msg_next;
         sh_reg    <= sh_next;
         crc_reg   <= crc_next;
         cnt_reg   <= cnt_next;
         per_reg   <= per_next;
         lo_reg    <= lo_next;
         idx_reg   <= idx_next;
         line_reg  <= line_next;
         bit_reg   <= bit_next;
         done_reg  <= done_next;
      end
   end

   // interrupt pin: a set in the clearing cycle wins
   logic int_reg, int_next, int_set, int_clr, busy_reg;
   assign int_set = int_en_i & (rx_ready_i | (done_next & tx_empty_i)); // R06
   assign int_clr = word_end & (tx_not_empty_i | rx_empty_i); // R12

   always_comb begin
      int_next = int_reg;
      if (int_set) begin
         int_next = 1'b1;
      end else if (int_clr) begin
         int_next = 1'b0; // R07
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         int_reg  <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         int_reg  <= int_next;
         busy_reg <= (state_next != dbt_pkg::DBT_ST_IDLE);
      end
   end

   assign channel_low_side_line_o = line_reg;
   assign driver_en_o             = drv_en_reg;
   assign oc_shutdown_o           = shut_reg;
   assign busy_o                  = busy_reg;
   assign frame_done_o            = done_reg;
   assign int_o                   = 1'b0;
   assign int_oe_o                = int_reg;

   // helper counters read only by the checks below
   logic        line_d_reg;
   logic [10:0] low_len_reg, gap_reg;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         line_d_reg  <= 1'b1;
         low_len_reg <= 11'h000;
         gap_reg     <= 11'h000;
      end else begin
         line_d_reg  <= line_reg;
         low_len_reg <= line_reg ? 11'h000 : low_len_reg + 11'h001;
         gap_reg     <= (!line_reg && line_d_reg) ? 11'h000 : gap_reg + 11'h001;
      end
   end

   a_bit_period_min: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R01
      (!line_reg && line_d_reg && state_reg == dbt_pkg::DBT_ST_LOW && idx_reg > 5'h01)
         |-> gap_reg >= 11'(`DBT_BIT_PERIOD_MIN_CYC - 1))
      else $error("bit period shorter than minimum");
   a_zero_low_time: assert property (@(posedge clk_i) disable iff (sys_rst_i || shut_reg) // R02
      (line_reg && !line_d_reg && !bit_reg) |-> low_len_reg == 11'(`DBT_LO0_CYC))
      else $error("zero bit low time wrong");
   a_one_low_time: assert property (@(posedge clk_i) disable iff (sys_rst_i || shut_reg) // R03
      (line_reg && !line_d_reg && bit_reg) |-> low_len_reg == 11'(`DBT_LO1_CYC))
      else $error("one bit low time wrong");
   a_start_window: assert property (@(posedge clk_i) disable iff (sys_rst_i || shut_reg) // R04
      (state_reg == dbt_pkg::DBT_ST_ARM && word_end)
         |-> ##1 line_reg[*8] ##[ST_MIN:ST_MAX] !line_reg)
      else $error("bus start outside latency window");
   a_int_assert: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R06
      (int_en_i && rx_ready_i) |=> int_oe_o)
      else $error("interrupt not asserted after receive data");
   a_int_release: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R07
      (word_end && (tx_not_empty_i || rx_empty_i) && !int_set) |=> !int_oe_o)
      else $error("interrupt not released at word end");
   a_oc_delay: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R08
      $rose(oc_shutdown_o) |-> ($past(oc_cnt_reg) >= 12'(`DBT_OC_MIN_CYC - 1)
         && $past(oc_cnt_reg) <= 12'(`DBT_OC_MAX_CYC - 1)) ##1 channel_low_side_line_o)
      else $error("overcurrent cut-off delay out of range");
   a_fixed_period: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R13
      (load && !spread_cfg_i.en && !$past(spread_cfg_i.en)) |=> per_reg == 11'(`DBT_BIT_CYC))
      else $error("period moved with spreading off");

endmodule // dbt_bit_timing

`default_nettype wire

/* sim/dbt_bus_slave.sv */
// bus slave model: times low pulses and bit periods on the channel line, decodes bits
// assumes the line is sampled on the block's own clock and idles high
`default_nettype none
`include "dbt_defs.svh"

module dbt_bus_slave (
   input  wire logic clk_i,
   input  wire logic line_i
);
   timeunit 1ns;
   timeprecision 1ps;

   int unsigned cyc      = 0;
   int unsigned fall_cyc = 0;
   logic        line_d   = 1'b1;
   int unsigned falls[$];
   int unsigned lo_len[$];
   int unsigned per_len[$];
   logic        bits[$];

   task automatic clear();
      falls.delete();
      lo_len.delete();
      per_len.delete();
      bits.delete();
      fall_cyc = 0;
   endtask

   // periods run fall to fall, so the last bit of a frame has none
   always @(posedge clk_i) begin
      cyc++;
      if (line_d && !line_i) begin
         if (falls.size() > 0)
            per_len.push_back(cyc - fall_cyc);
         fall_cyc = cyc;
         falls.push_back(cyc);
      end else if (!line_d && line_i && falls.size() > 0) begin
         lo_len.push_back(cyc - fall_cyc);
         // short low is a one, long low a zero; threshold at half the nominal bit period
         bits.push_back(logic'((cyc - fall_cyc) < `DBT_BIT_CYC / 2));
      end
      line_d = line_i;
   end
endmodule // dbt_bus_slave

`default_nettype wire

/* sim/test_diff_bus_bit_timing.sv */
// self-checking bench: frames, start latency, interrupt pin and overcurrent cut-off
// assumes the package, the design and the bus slave model are compiled first
`default_nettype none
`include "dbt_defs.svh"

`define DBT_CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("CHECK FAILED at %0t ns: got %0h expected %0h", $time, (got), (exp)); \
      end \
   end

module test_diff_bus_bit_timing;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int BIT  = `DBT_BIT_CYC;
   localparam int TMIN = (6670 * 125 + 999) / 1000;
   localparam int TRIM = 600 * 125 / 1000;
   localparam int TOL  = 200 * 125 / 1000;
   localparam int STEP = 10;

   logic clk_i = 1'b0, sys_rst_i = 1'b1, spi_cs_n_i = 1'b1, spi_sclk_i = 1'b1;
   logic tx_start_i = 1'b0, int_en_i = 1'b0, rx_ready_i = 1'b0, tx_empty_i = 1'b0;
   logic tx_not_empty_i = 1'b0, rx_empty_i = 1'b0, oc_detect_i = 1'b0, oc_clear_i = 1'b0;
   dbt_pkg::dbt_msg_t        tx_msg_i     = '0;
   dbt_pkg::dbt_spread_cfg_t spread_cfg_i = '0;
   logic channel_low_side_line_o, driver_en_o, oc_shutdown_o, busy_o;
   logic frame_done_o, int_o, int_oe_o;
   int   fails      = 0;
   int   num_checks = 0;

   dbt_bit_timing i_dbt_bit_timing (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_cs_n_i(spi_cs_n_i),
      .spi_sclk_i(spi_sclk_i), .tx_start_i(tx_start_i), .tx_msg_i(tx_msg_i),
      .spread_cfg_i(spread_cfg_i), .int_en_i(int_en_i), .rx_ready_i(rx_ready_i),
      .tx_empty_i(tx_empty_i), .tx_not_empty_i(tx_not_empty_i), .rx_empty_i(rx_empty_i),
      .oc_detect_i(oc_detect_i), .oc_clear_i(oc_clear_i),
      .channel_low_side_line_o(channel_low_side_line_o), .driver_en_o(driver_en_o),
      .oc_shutdown_o(oc_shutdown_o), .busy_o(busy_o), .frame_done_o(frame_done_o),
      .int_o(int_o), .int_oe_o(int_oe_o)
   );

   dbt_bus_slave i_dbt_bus_slave (.clk_i(clk_i), .line_i(channel_low_side_line_o));

   always #4 clk_i = ~clk_i;

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic sclk_pulse();
      spi_sclk_i = 1'b0;
      tick(STEP);
      spi_sclk_i = 1'b1;
      tick(STEP);
   endtask

   // burst mode holds cs low long after the next byte starts, so a wrong reference shows
   task automatic spi_word(input bit burst, output int unsigned r);
      spi_cs_n_i = 1'b0;
      tick(STEP + 3);
      repeat (8) sclk_pulse();
      if (burst) begin
         spi_sclk_i = 1'b0;
         tick(STEP);
         spi_sclk_i = 1'b1;
         r = i_dbt_bus_slave.cyc;
         tick(400);
      end
      tick(STEP + 3);
      spi_cs_n_i = 1'b1;
      if (!burst)
         r = i_dbt_bus_slave.cyc;
      tick(STEP);
   endtask

   function automatic logic lo_ok(input int unsigned lo, input logic one);
      int e;
      e = (one ? BIT / 3 : 2 * BIT / 3) - TRIM;
      return (int'(lo) >= e - TOL) && (int'(lo) <= e + TOL);
   endfunction

   task automatic per_stats(output int lo, output int hi);
      lo = 100000;
      hi = 0;
      foreach (i_dbt_bus_slave.per_len[i]) begin
         if (int'(i_dbt_bus_slave.per_len[i]) < lo)
            lo = int'(i_dbt_bus_slave.per_len[i]);
         if (int'(i_dbt_bus_slave.per_len[i]) > hi)
            hi = int'(i_dbt_bus_slave.per_len[i]);
      end
   endtask

   task automatic send_frame(input dbt_pkg::dbt_msg_t m, input bit burst, input bit poke,
                             output int lat);
      logic        exp_bits[$];
      logic [7:0]  crc;
      int unsigned r;
      int          n;
      crc = `DBT_CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         if (i < int'(m.nbits)) begin
            exp_bits.push_back(m.data[i]);
            crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ m.data[i]) ? `DBT_CRC_POLY : 8'h00);
         end
      end
      for (int i = 7; i > 7 - int'(m.crc_len); i--)
         exp_bits.push_back(crc[i]);
      i_dbt_bus_slave.clear();
      tx_msg_i = m;
      tx_start_i = 1'b1;
      tick();
      tx_start_i = 1'b0;
      tick();
      `DBT_CHK(busy_o, 1'b1);
      spi_word(burst, r);
      n = 0;
      while (i_dbt_bus_slave.falls.size() == 0 && n < 2 * BIT) begin
         tick();
         n++;
      end
      lat = int'(i_dbt_bus_slave.falls[0]) - int'(r);
      if (poke) begin
         tx_msg_i = ~m;
         tx_start_i = 1'b1;
         tick();
         tx_start_i = 1'b0;
      end
      n = 0;
      while (frame_done_o !== 1'b1 && n < 30000) begin
         tick();
         n++;
      end
      `DBT_CHK(frame_done_o, 1'b1);
      `DBT_CHK(busy_o, 1'b0);
      `DBT_CHK(i_dbt_bus_slave.bits.size(), exp_bits.size());
      foreach (exp_bits[i]) begin
         `DBT_CHK(i_dbt_bus_slave.bits[i], exp_bits[i]);
         `DBT_CHK(lo_ok(i_dbt_bus_slave.lo_len[i], exp_bits[i]), 1'b1);
      end
   endtask

   task automatic t_reset();
      `DBT_CHK(channel_low_side_line_o, 1'b1);
      `DBT_CHK({driver_en_o, oc_shutdown_o}, 2'b10);
      `DBT_CHK({busy_o, frame_done_o}, 2'b00);
      `DBT_CHK({int_oe_o, int_o}, 2'b00);
   endtask

   task automatic t_int_rx();
      int unsigned r;
      rx_ready_i = 1'b1;
      tick();
      rx_ready_i = 1'b0;
      tick(BIT / 3 + TOL);
      `DBT_CHK(int_oe_o, 1'b0);
      int_en_i = 1'b1;
      rx_ready_i = 1'b1;
      tick();
      rx_ready_i = 1'b0;
      tick(BIT / 3 + TOL);
      `DBT_CHK(int_oe_o, 1'b1);
      spi_word(1'b0, r);
      `DBT_CHK(int_oe_o, 1'b1);
      rx_empty_i = 1'b1;
      spi_word(1'b0, r);
      `DBT_CHK(int_oe_o, 1'b0);
      rx_empty_i = 1'b0;
      int_en_i = 1'b0;
   endtask

   task automatic t_tx_crc();
      dbt_pkg::dbt_msg_t m;
      int unsigned       r;
      int                lat, lo, hi;
      m = '{data: 16'h00a5, nbits: 5'h08, crc_len: 4'h8};
      int_en_i = 1'b1;
      tx_empty_i = 1'b1;
      send_frame(m, 1'b0, 1'b1, lat);
      `DBT_CHK(lat >= BIT / 3 && lat <= 2 * BIT / 3, 1'b1);
      per_stats(lo, hi);
      `DBT_CHK(lo == BIT && hi == BIT, 1'b1);
      `DBT_CHK(lo >= TMIN, 1'b1);
      tick(BIT / 3 + TOL);
      `DBT_CHK(int_oe_o, 1'b1);
      tx_empty_i = 1'b0;
      tx_not_empty_i = 1'b1;
      spi_word(1'b0, r);
      `DBT_CHK(int_oe_o, 1'b0);
      tx_not_empty_i = 1'b0;
      int_en_i = 1'b0;
   endtask

   task automatic t_burst();
      dbt_pkg::dbt_msg_t m;
      int                lat;
      m = '{data: 16'hf00f, nbits: 5'h10, crc_len: 4'h0};
      send_frame(m, 1'b1, 1'b0, lat);
      `DBT_CHK(lat >= BIT / 3 && lat <= 2 * BIT / 3, 1'b1);
   endtask

   task automatic t_spread();
      dbt_pkg::dbt_spread_cfg_t cfg[3];
      dbt_pkg::dbt_msg_t        m;
      int                       dev[3];
      int                       lat, lo, hi;
      cfg[0] = '{en: 1'b1, spread_deviation_sel: `DBT_DEV_SEL_NARROW};
      cfg[1] = '{en: 1'b1, spread_deviation_sel: `DBT_DEV_SEL_WIDE};
      cfg[2] = '{en: 1'b1, spread_deviation_sel: 2'b11};
      dev = '{600 * 125 / 1000, 1100 * 125 / 1000, 0};
      m = '{data: 16'h005a, nbits: 5'h08, crc_len: 4'h4};
      for (int i = 0; i < 3; i++) begin
         spread_cfg_i = cfg[i];
         send_frame(m, 1'b0, 1'b0, lat);
         per_stats(lo, hi);
         `DBT_CHK(lat >= BIT / 3 && lat <= 4 * BIT / 3, 1'b1);
         `DBT_CHK(lo >= BIT - dev[i] && hi <= BIT + dev[i] && lo >= TMIN, 1'b1);
         `DBT_CHK((hi > lo) == (dev[i] > 0), 1'b1);
      end
      spread_cfg_i = '0;
   endtask

   task automatic t_overcurrent();
      int unsigned r;
      int          n;
      oc_detect_i = 1'b1;
      tick(200);
      oc_detect_i = 1'b0;
      tick(10);
      `DBT_CHK(oc_shutdown_o, 1'b0);
      i_dbt_bus_slave.clear();
      tx_msg_i = '{data: 16'h0033, nbits: 5'h08, crc_len: 4'h0};
      tx_start_i = 1'b1;
      tick();
      tx_start_i = 1'b0;
      spi_word(1'b0, r);
      // cut-off lands inside the first zero's low pulse, so the forced idle shows
      oc_detect_i = 1'b1;
      n = 0;
      while (oc_shutdown_o !== 1'b1 && n < 3000) begin
         tick();
         n++;
      end
      `DBT_CHK(n >= 250 && n <= 2500, 1'b1);
      `DBT_CHK({i_dbt_bus_slave.falls.size() == 1, channel_low_side_line_o}, 2'b10);
      tick();
      `DBT_CHK({driver_en_o, channel_low_side_line_o, busy_o}, 3'b010);
      oc_detect_i = 1'b0;
      tick(5);
      oc_clear_i = 1'b1;
      tick();
      oc_clear_i = 1'b0;
      tick();
      `DBT_CHK({oc_shutdown_o, driver_en_o}, 2'b01);
   endtask

   task automatic test_done();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      tick(3);
      sys_rst_i = 1'b0;
      tick(4);
      t_reset();
      t_int_rx();
      t_tx_crc();
      t_burst();
      t_spread();
      t_overcurrent();
      test_done();
   end

   // the whole sequence needs about 70k cycles
   initial begin
      repeat (100000) @(posedge clk_i);
      fails++;
      test_done();
   end
endmodule // test_diff_bus_bit_timing

`default_nettype wire
